// ===== hw/link_timing.sv
/*
 * Sample latency line, SYSREF-aligned multiframe clock, multiframe start
 * timing and the sync / lane alignment / data sequencing of one link.
 * Assumes i_clk is the sampling clock model (one cycle per sample); the
 * configuration inputs come from logic on the same clock, while SYSREF
 * and the sync request arrive from pins.
 */
`timescale 1ns/1ps

// Behaviour
// - One sample taken every sampling clock cycle
// - Decimate 4 latency 292 or 284
// - Decimate 8 latency 384, 368, 392
// - Decimate 16 latency 608 or 560
// - Decimate 10 gives 386, 20 gives 568
// - Decimate 32 latency 1044 or 948
// - Multiframe boundary 40 periods after SYSREF latch
// - Multiframe start 60.7 or 51.5 after boundary
// - Double rate: start 52.7 or 43.9 after
// - Up to three extra propagation cycles allowed
// - Alignment sequence lasts four multiframes before data
// - Lane rate one, 1.25, two or 2.5 times
module link_timing
	import link_timing_pkg::*;
#(
	parameter int SAMPLE_W = 16, // Sample word width
	parameter int DEPTH_LOG2 = 11, // Latency line depth, log2
	parameter int FRAME_CYC = 4, // Sampling periods per frame
	parameter int LMFC_CYC = 128 // Sampling periods per multiframe
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [5:0] i_decim,
	input wire logic i_ddr,
	input wire logic i_five_four_rate_option,
	input wire logic i_sysref,
	input wire logic i_sync_n,
	input wire logic [SAMPLE_W-1:0] i_sample,
	output logic [SAMPLE_W-1:0] o_sample,
	output logic o_sample_valid,
	output logic o_lmfc,
	output logic o_mf_start,
	output logic [1:0] o_lane_code,
	output logic [3:0] o_rate_x4,
	output logic o_cfg_err,
	output logic o_link_up
);

	////////////////////////////////////////////////////////////////////////////
	// Configuration decode

	logic [10:0] lat_nxt; // Latency for the present settings
	logic [7:0] txd_nxt; // Multiframe start delay
	logic [3:0] rate_nxt; // Lane rate factor
	logic err_nxt; // Unsupported setting
	logic [10:0] lat_r;
	logic [7:0] txd_r;

	// Table lookup on decimation and both rate options
	always_comb begin
		lat_nxt = LAT_D8;
		err_nxt = 1'b0;
		case (i_decim)
			6'h04: begin
				lat_nxt = i_five_four_rate_option ? LAT_D4_DDR_P54 : LAT_D4_DDR;
				err_nxt = ~i_ddr; // Too fast for single rate lanes
			end
			6'h08: begin
				if (i_five_four_rate_option) begin
					lat_nxt = LAT_D8_P54;
				end else begin
					lat_nxt = i_ddr ? LAT_D8_DDR : LAT_D8;
				end
			end
			6'h0A: begin
				lat_nxt = LAT_D10;
				err_nxt = i_five_four_rate_option;
			end
			6'h10: lat_nxt = i_five_four_rate_option ? LAT_D16_P54 : LAT_D16;
			6'h14: begin
				lat_nxt = LAT_D20;
				err_nxt = i_five_four_rate_option;
			end
			6'h20: begin
				lat_nxt = i_five_four_rate_option ? LAT_D32_P54 : LAT_D32;
				err_nxt = i_ddr & i_five_four_rate_option;
			end
			default: err_nxt = 1'b1;
		endcase
		// Multiframe start delay depends only on the rate options
		case ({i_ddr, i_five_four_rate_option})
			2'b00: txd_nxt = TXD_CYC;
			2'b01: txd_nxt = TXD_P54_CYC;
			2'b10: txd_nxt = TXD_DDR_CYC;
			default: txd_nxt = TXD_DDR_P54_CYC;
		endcase
		case ({i_ddr, i_five_four_rate_option})
			2'b00: rate_nxt = RATE_X4_BASE;
			2'b01: rate_nxt = RATE_X4_P54;
			2'b10: rate_nxt = RATE_X4_DDR;
			default: rate_nxt = RATE_X4_BOTH;
		endcase
	end

	// Registered configuration; one cycle of settling is harmless here
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lat_r <= LAT_D8;
			txd_r <= TXD_CYC;
			o_rate_x4 <= RATE_X4_BASE;
			o_cfg_err <= 1'b0;
		end else begin
			lat_r <= lat_nxt;
			txd_r <= txd_nxt;
			o_rate_x4 <= rate_nxt;
			o_cfg_err <= err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Latency line: a circular buffer written every cycle

	logic [SAMPLE_W-1:0] line_mem [2**DEPTH_LOG2]; // Sample history
	logic [DEPTH_LOG2-1:0] wr_ptr_r; // Next write slot
	logic [DEPTH_LOG2-1:0] rd_ptr; // Slot written lat_r cycles ago
	logic [DEPTH_LOG2:0] fill_r; // Samples held, saturating

	assign rd_ptr = wr_ptr_r - DEPTH_LOG2'(lat_r);

	// One sample stored per sampling period, no gaps
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end

	// Memory has no reset so it maps onto block RAM
	always_ff @(posedge i_clk) begin
		line_mem[wr_ptr_r] <= i_sample;
	end

	// Output stands lat_r + 1 cycles behind the input, one cycle being the output register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sample <= '0;
		end else begin
			o_sample <= line_mem[rd_ptr];
		end
	end

	// Valid only once the line holds a full latency of history
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fill_r <= '0;
			o_sample_valid <= 1'b0;
		end else begin
			if (fill_r < (DEPTH_LOG2+1)'(2**DEPTH_LOG2)) begin
				fill_r <= fill_r + 1'b1;
			end
			o_sample_valid <= (fill_r >= (DEPTH_LOG2+1)'(lat_r)) && !o_cfg_err;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; their two cycles sit inside the allowed margin

	logic sysref_s1_r, sysref_s2_r, sysref_s3_r;
	logic sync_s1_r, sync_n_s2_r;
	logic sysref_edge; // First cycle SYSREF seen high

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sysref_s1_r <= 1'b0;
			sysref_s2_r <= 1'b0;
			sysref_s3_r <= 1'b0;
			sync_s1_r <= 1'b1;
			sync_n_s2_r <= 1'b1;
		end else begin
			sysref_s1_r <= i_sysref;
			sysref_s2_r <= sysref_s1_r;
			sysref_s3_r <= sysref_s2_r;
			sync_s1_r <= i_sync_n;
			sync_n_s2_r <= sync_s1_r;
		end
	end

	assign sysref_edge = sysref_s2_r && !sysref_s3_r;

	////////////////////////////////////////////////////////////////////////////
	// Local multiframe clock and frame enable

	logic [5:0] sr_cnt_r; // Countdown from SYSREF latch
	logic sr_arm_r; // Countdown running
	logic [$clog2(LMFC_CYC)-1:0] lmfc_cnt_r; // Phase in multiframe
	logic [$clog2(FRAME_CYC)-1:0] frame_cnt_r; // Phase in frame
	logic lmfc_hit; // Boundary next cycle
	logic frame_ce; // One cycle per frame

	assign lmfc_hit = sr_arm_r ? (sr_cnt_r == 6'h01) :
		(lmfc_cnt_r == ($clog2(LMFC_CYC))'(LMFC_CYC - 1));
	assign frame_ce = (frame_cnt_r == ($clog2(FRAME_CYC))'(FRAME_CYC - 1));

	// A new SYSREF realigns the boundary; free running otherwise
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sr_cnt_r <= '0;
			sr_arm_r <= 1'b0;
			lmfc_cnt_r <= '0;
			frame_cnt_r <= '0;
			o_lmfc <= 1'b0;
		end else begin
			if (sysref_edge) begin
				sr_cnt_r <= 6'(SYSREF_LMFC_CYC - 1);
				sr_arm_r <= 1'b1;
			end else if (sr_arm_r) begin
				sr_cnt_r <= sr_cnt_r - 1'b1;
				sr_arm_r <= (sr_cnt_r != 6'h01);
			end
			o_lmfc <= lmfc_hit;
			if (lmfc_hit) begin
				lmfc_cnt_r <= '0;
				frame_cnt_r <= '0;
			end else begin
				lmfc_cnt_r <= lmfc_cnt_r + 1'b1;
				frame_cnt_r <= frame_ce ? '0 : frame_cnt_r + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Multiframe start, a fixed delay after each boundary

	logic [7:0] mf_cnt_r; // Countdown to multiframe start
	logic mf_arm_r;

	// Delay assumed shorter than one multiframe
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mf_cnt_r <= '0;
			mf_arm_r <= 1'b0;
			o_mf_start <= 1'b0;
		end else begin
			o_mf_start <= mf_arm_r && (mf_cnt_r == 8'h01);
			if (o_lmfc) begin
				mf_cnt_r <= txd_r - 1'b1;
				mf_arm_r <= 1'b1;
			end else if (mf_arm_r) begin
				mf_cnt_r <= mf_cnt_r - 1'b1;
				mf_arm_r <= (mf_cnt_r != 8'h01);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sync request qualification and link sequencing

	logic [2:0] sync_frames_r; // Frames sync held, saturating
	logic sync_qual_r; // Held long enough to resync
	logic [2:0] ila_cnt_r; // Multiframes of alignment sent
	link_state_t state_r;

	// Short sync pulses are ignored; a long one forces a resync
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync_frames_r <= '0;
			sync_qual_r <= 1'b0;
		end else if (sync_n_s2_r) begin
			sync_frames_r <= '0;
			sync_qual_r <= 1'b0;
		end else if (frame_ce && sync_frames_r != SYNC_MIN_FRAMES) begin
			sync_frames_r <= sync_frames_r + 1'b1;
			sync_qual_r <= (sync_frames_r == SYNC_MIN_FRAMES - 1'b1);
		end
	end

	// Link state walk
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= ST_SYNC;
			ila_cnt_r <= '0;
		end else if (sync_qual_r) begin
			state_r <= ST_SYNC;
			ila_cnt_r <= '0;
		end else begin
			case (state_r)
				ST_SYNC: begin
					// Release waits for the next boundary, then the multiframe start after it
					if (sync_n_s2_r && sync_frames_r == '0 && o_lmfc) begin
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (o_mf_start) begin
						state_r <= ST_ILA;
						ila_cnt_r <= '0;
					end
				end
				ST_ILA: begin
					if (o_mf_start) begin
						ila_cnt_r <= ila_cnt_r + 1'b1;
						if (ila_cnt_r == ILA_MF - 1'b1) begin
							state_r <= ST_DATA;
						end
					end
				end
				ST_DATA: state_r <= ST_DATA;
				default: state_r <= ST_SYNC;
			endcase
		end
	end

	// Lane content follows the state, registered
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_lane_code <= LANE_K;
			o_link_up <= 1'b0;
		end else begin
			case (state_r)
				ST_ILA: o_lane_code <= LANE_ILA;
				ST_DATA: o_lane_code <= LANE_DATA;
				default: o_lane_code <= LANE_K;
			endcase
			o_link_up <= (state_r == ST_DATA);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	// First edge after release still sees the reset value in $past
	sample_rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!$past(i_rst) |-> wr_ptr_r == $past(wr_ptr_r) + 1'b1)
		else $error("sample slot skipped");
	lat_d4_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_decim == 6'h04 && i_ddr && !i_five_four_rate_option ##1 $stable(i_decim)
		|-> lat_r == 11'd292 && (wr_ptr_r - rd_ptr) == 11'd292)
		else $error("decimate 4 latency wrong");
	lat_d8_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_decim == 6'h08 && i_ddr && !i_five_four_rate_option |=> lat_r == 11'd392)
		else $error("decimate 8 latency wrong");
	lat_d16_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_decim == 6'h10 && i_five_four_rate_option |=> lat_r == 11'd560)
		else $error("decimate 16 latency wrong");
	lat_d20_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_decim == 6'h14 && !i_five_four_rate_option |=> lat_r == 11'd568 && !o_cfg_err)
		else $error("decimate 20 latency wrong");
	lat_d32_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_decim == 6'h20 && !i_five_four_rate_option |=> lat_r == 11'd1044)
		else $error("decimate 32 latency wrong");
	sysref_lmfc_a: assert property (@(posedge i_clk) disable iff (i_rst)
		sysref_edge |-> ##40 o_lmfc)
		else $error("boundary not 40 after sysref");
	tx_delay_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lmfc && txd_r == 8'd61 |-> ##61 o_mf_start)
		else $error("multiframe start delay wrong");
	tx_ddr_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_lmfc && txd_r == 8'd44 |-> ##44 o_mf_start)
		else $error("double rate start delay wrong");
	ila_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
		state_r == ST_ILA ##1 state_r == ST_DATA |-> $past(ila_cnt_r) == 3'd3)
		else $error("alignment sequence length wrong");
	sync_qual_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(sync_qual_r) |-> !sync_n_s2_r && sync_frames_r == 3'd4)
		else $error("resync on short request");
	rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ddr && i_five_four_rate_option |=> o_rate_x4 == 4'hA)
		else $error("lane rate factor wrong");

	link_up_c: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_link_up));
	realign_c: cover property (@(posedge i_clk) disable iff (i_rst) sysref_edge ##40 o_lmfc);
	resync_c: cover property (@(posedge i_clk) disable iff (i_rst)
		state_r == ST_DATA ##1 state_r == ST_SYNC);
	valid_c: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_sample_valid));

endmodule // link_timing

// ===== hw/link_timing_pkg.sv
/*
 * Constants for the sampling-path latency and link alignment block.
 * Assumes one system clock cycle stands for one sampling clock period.
 */
package link_timing_pkg;
	// Sampling clock range in GHz; the block clock stands in for it
	localparam int SCLK_MIN_GHZ = 1;
	localparam int SCLK_MAX_GHZ = 4;
	localparam int CLK_HZ = 20_000_000;

	// Converter plus downconverter latency, sampling periods
	localparam logic [10:0] LAT_D4_DDR = 11'h124; // 292
	localparam logic [10:0] LAT_D4_DDR_P54 = 11'h11C; // 284
	localparam logic [10:0] LAT_D8 = 11'h180; // 384
	localparam logic [10:0] LAT_D8_P54 = 11'h170; // 368
	localparam logic [10:0] LAT_D8_DDR = 11'h188; // 392
	localparam logic [10:0] LAT_D10 = 11'h182; // 386
	localparam logic [10:0] LAT_D16 = 11'h260; // 608
	localparam logic [10:0] LAT_D16_P54 = 11'h230; // 560
	localparam logic [10:0] LAT_D20 = 11'h238; // 568
	localparam logic [10:0] LAT_D32 = 11'h414; // 1044
	localparam logic [10:0] LAT_D32_P54 = 11'h3B4; // 948

	// Latched SYSREF to local multiframe boundary
	localparam int SYSREF_LMFC_CYC = 40;

	// Boundary to multiframe start, in tenths of a sampling period
	localparam int TXD_X10 = 607;
	localparam int TXD_P54_X10 = 515;
	localparam int TXD_DDR_X10 = 527;
	localparam int TXD_DDR_P54_X10 = 439;
	// Least delays round up to whole cycles
	localparam logic [7:0] TXD_CYC = 8'((TXD_X10 + 9) / 10);
	localparam logic [7:0] TXD_P54_CYC = 8'((TXD_P54_X10 + 9) / 10);
	localparam logic [7:0] TXD_DDR_CYC = 8'((TXD_DDR_X10 + 9) / 10);
	localparam logic [7:0] TXD_DDR_P54_CYC = 8'((TXD_DDR_P54_X10 + 9) / 10);

	// Extra propagation an implementation may add
	localparam int PROP_MAX_CYC = 3;

	localparam logic [2:0] ILA_MF = 3'h4; // multiframes of alignment sequence
	localparam logic [2:0] SYNC_MIN_FRAMES = 3'h4; // frames of held sync request

	// Lane bit rate as multiple of sample rate, times four
	localparam logic [3:0] RATE_X4_BASE = 4'h4;
	localparam logic [3:0] RATE_X4_P54 = 4'h5;
	localparam logic [3:0] RATE_X4_DDR = 4'h8;
	localparam logic [3:0] RATE_X4_BOTH = 4'hA;

	// Link states, Gray coded along sync, wait, align, data
	typedef enum logic [1:0] {
		ST_SYNC = 2'h0,
		ST_WAIT = 2'h1,
		ST_ILA = 2'h3,
		ST_DATA = 2'h2
	} link_state_t;

	// What the lane carries
	typedef enum logic [1:0] {
		LANE_K = 2'h0,
		LANE_ILA = 2'h1,
		LANE_DATA = 2'h2
	} lane_code_t;
endpackage

// ===== test/link_receiver_model.sv
/*
 * Behavioural far-end receiver: drives the active-low sync request.
 * Assumes i_lmfc is the block's boundary pulse on the same clock.
 */
`timescale 1ns/1ps

module link_receiver_model #(
	parameter int FRAME_CYC = 4 // Sampling periods per frame
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_lmfc,
	input wire logic i_resync,
	input wire logic i_short,
	output logic o_sync_n
);
	logic [1:0] seen_r; // Boundaries counted while requesting
	logic [4:0] glitch_r; // Cycles left of a too-short request

	////////////////////////////////////////////////////////////////
	// Request from reset, on command, or as a deliberate short glitch
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sync_n <= 1'b0;
			seen_r <= 2'h0;
			glitch_r <= 5'h00;
		end else if (i_resync) begin
			// Held over two boundaries, far above four frames
			o_sync_n <= 1'b0;
			seen_r <= 2'h0;
		end else if (i_short) begin
			// Only two frames long, so the block must ignore it
			o_sync_n <= 1'b0;
			glitch_r <= 5'(2 * FRAME_CYC);
		end else if (glitch_r != 5'h00) begin
			glitch_r <= glitch_r - 5'h01;
			if (glitch_r == 5'h01) begin
				o_sync_n <= 1'b1;
			end
		end else if (!o_sync_n && i_lmfc) begin
			// Release just after a boundary: full setup to the next one
			if (seen_r == 2'h1) begin
				o_sync_n <= 1'b1;
			end
			seen_r <= seen_r + 2'h1;
		end
	end
endmodule // link_receiver_model

// ===== test/tb.sv
/*
 * Self-checking bench for the sample latency and link timing block.
 * Assumes one clock cycle stands for one sampling period and that the
 * receiver model answers the sync handshake.
 */
`timescale 1ns/1ps

module tb
	import link_timing_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [5:0] i_decim = 6'h08;
	logic i_ddr = 1'b0;
	logic i_five_four_rate_option = 1'b0;
	logic i_sysref = 1'b0;
	logic i_sync_n;
	logic [15:0] i_sample = 16'h0000; // Ramp, one new sample a cycle
	logic resync = 1'b0; // Commands to the receiver model
	logic short_req = 1'b0;
	logic [15:0] o_sample;
	logic o_sample_valid, o_lmfc, o_mf_start, o_cfg_err, o_link_up;
	logic [1:0] o_lane_code;
	logic [3:0] o_rate_x4;
	int n_mismatch = 0;
	int checked = 0;

	link_timing u_link_timing (
		.i_clk(i_clk), .i_rst(i_rst), .i_decim(i_decim), .i_ddr(i_ddr),
		.i_five_four_rate_option(i_five_four_rate_option), .i_sysref(i_sysref),
		.i_sync_n(i_sync_n), .i_sample(i_sample), .o_sample(o_sample),
		.o_sample_valid(o_sample_valid), .o_lmfc(o_lmfc), .o_mf_start(o_mf_start),
		.o_lane_code(o_lane_code), .o_rate_x4(o_rate_x4), .o_cfg_err(o_cfg_err),
		.o_link_up(o_link_up)
	);

	link_receiver_model u_link_receiver_model (
		.i_clk(i_clk), .i_rst(i_rst), .i_lmfc(o_lmfc), .i_resync(resync),
		.i_short(short_req), .o_sync_n(i_sync_n)
	);

	////////////////////////////////////////////////////////////////
	// Clock, sample ramp and watchdog
	initial begin
		forever #25 i_clk = ~i_clk;
	end

	always @(posedge i_clk) i_sample <= i_sample + 16'h0001;

	// Whole run is under 13000 cycles; over four times that is a hang
	initial begin
		repeat (60000) @(posedge i_clk);
		$display("watchdog expired");
		n_mismatch++;
		conclude();
	end

	////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// Negedges until the chosen pulse; a miss gives a count of 2000
	task automatic gap(input bit mf, output int n);
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (!(mf ? o_mf_start === 1'b1 : o_lmfc === 1'b1) && n < 2000);
	endtask

	task automatic conclude();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	// Every decimation and option pair; a non-listed factor as well
	task automatic t_config();
		int dl[7] = '{4, 8, 10, 16, 20, 32, 5};
		logic [3:0] rx[4] = '{4'h4, 4'h5, 4'h8, 4'hA};
		bit bad;
		for (int d = 0; d < 7; d++) begin
			for (int c = 0; c < 4; c++) begin
				@(posedge i_clk);
				i_decim <= 6'(dl[d]);
				i_ddr <= c[1];
				i_five_four_rate_option <= c[0];
				repeat (3) @(negedge i_clk);
				bad = (dl[d] == 4) ? !c[1] : (dl[d] == 10 || dl[d] == 20) ? c[0] :
					(dl[d] == 32) ? (c == 3) : (dl[d] != 8 && dl[d] != 16);
				chk("cfg_err", 16'(o_cfg_err), 16'(bad));
				if (bad) begin
					chk("valid_refused", 16'(o_sample_valid), 16'h0000);
				end else begin
					chk("rate_x4", 16'(o_rate_x4), 16'(rx[c]));
				end
			end
		end
		$display("config test done");
	endtask

	// Ramp in, ramp out: output lags the input by the latency plus one cycle
	task automatic t_latency();
		int td[17] = '{4, 4, 8, 8, 8, 8, 10, 10, 16, 16, 16, 16, 20, 20, 32, 32, 32};
		bit tr[17] = '{1, 1, 0, 0, 1, 1, 0, 1, 0, 0, 1, 1, 0, 1, 0, 0, 1};
		bit tf[17] = '{0, 1, 0, 1, 0, 1, 0, 0, 0, 1, 0, 1, 0, 0, 0, 1, 0};
		int tl[17] = '{292, 284, 384, 368, 392, 368, 386, 386, 608, 560, 608, 560,
			568, 568, 1044, 948, 1044};
		for (int k = 0; k < 17; k++) begin
			@(posedge i_clk);
			i_decim <= 6'(td[k]);
			i_ddr <= tr[k];
			i_five_four_rate_option <= tf[k];
			repeat (tl[k] + 6) @(posedge i_clk);
			// Several cycles in a row: one sample taken per cycle
			for (int j = 0; j < 3; j++) begin
				@(negedge i_clk);
				chk("sample", o_sample, i_sample - 16'(tl[k] + 1));
			end
			chk("valid", 16'(o_sample_valid), 16'h0001);
		end
		$display("latency test done");
	endtask

	// 40 after latch, 2 synchroniser, 1 count offset; second pulse restarts
	task automatic t_sysref();
		int n;
		// Start just after a free boundary so none lands before the latch
		gap(1'b0, n);
		repeat (2) begin
			repeat (4) @(posedge i_clk);
			i_sysref <= 1'b1;
			gap(1'b0, n);
			chk("sysref_gap", 16'(n), 16'h002B);
			gap(1'b0, n);
			chk("lmfc_period", 16'(n), 16'h0080);
			@(posedge i_clk);
			i_sysref <= 1'b0;
		end
		$display("sysref test done");
	endtask

	// Boundary to multiframe start for each option pair, rounded up
	task automatic t_mf();
		int dx[4] = '{61, 52, 53, 44};
		int n;
		for (int c = 0; c < 4; c++) begin
			@(posedge i_clk);
			i_decim <= 6'h08;
			i_ddr <= c[1];
			i_five_four_rate_option <= c[0];
			repeat (2) gap(1'b0, n);
			gap(1'b1, n);
			chk("mf_delay", 16'(n), 16'(dx[c]));
		end
		$display("multiframe test done");
	endtask

	// Resync: back to K, then four multiframes of alignment, then data
	task automatic t_link();
		int n = 0;
		@(posedge i_clk);
		resync <= 1'b1;
		@(posedge i_clk);
		resync <= 1'b0;
		while (o_lane_code !== LANE_K && n < 40) begin
			@(negedge i_clk);
			n++;
		end
		chk("lane_k", 16'(o_lane_code), 16'(LANE_K));
		chk("link_down", 16'(o_link_up), 16'h0000);
		while (o_lane_code !== LANE_ILA && n < 1000) begin
			@(negedge i_clk);
			n++;
		end
		n = 0;
		while (o_lane_code === LANE_ILA && n < 1000) begin
			n++;
			@(negedge i_clk);
		end
		chk("ila_cycles", 16'(n), 16'h0200);
		chk("lane_data", 16'(o_lane_code), 16'(LANE_DATA));
		@(negedge i_clk);
		chk("link_up", 16'(o_link_up), 16'h0001);
		$display("link test done");
	endtask

	// Two-frame request is too short and must not drop the link
	task automatic t_glitch();
		bit lost = 1'b0;
		@(posedge i_clk);
		short_req <= 1'b1;
		@(posedge i_clk);
		short_req <= 1'b0;
		repeat (200) begin
			@(negedge i_clk);
			lost |= (o_link_up !== 1'b1) || (o_lane_code !== LANE_DATA);
		end
		chk("glitch_ignored", 16'(lost), 16'h0000);
		$display("glitch test done");
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_config();
		t_latency();
		t_sysref();
		t_mf();
		t_link();
		t_glitch();
		conclude();
	end
endmodule // tb
